// File: common/interval_prescaler_map.vh
`ifndef INTERVAL_PRESCALER_MAP_VH
`define INTERVAL_PRESCALER_MAP_VH

// Register offsets
`define IPS_ADDR_CONTROL 3'h0
`define IPS_ADDR_STATUS 3'h1
`define IPS_ADDR_FLAG_CLEAR 3'h2
`define IPS_ADDR_COUNT_LO 3'h3
`define IPS_ADDR_COUNT_HI 3'h4

// Control register fields, then the status register flag bit
`define IPS_BIT_FLAG 7
`define IPS_BIT_ENABLE 6
`define IPS_SEL_HI 3
`define IPS_SEL_LO 1
`define IPS_BIT_CLEAR 0
`define IPS_BIT_STATUS_FLAG 0

// Reset values
`define IPS_CONTROL_RESET 8'h00
`define IPS_COUNT_RELOAD 16'hffff
`define IPS_WRAP_RELOAD 1'h1
`define IPS_ZERO_BYTE 8'h00

// Tap stage (n - 1) for each interval select code
`define IPS_TAP_SEL0 5'h0a
`define IPS_TAP_SEL1 5'h0b
`define IPS_TAP_SEL2 5'h0c
`define IPS_TAP_SEL3 5'h0d
`define IPS_TAP_SEL4 5'h09
`define IPS_TAP_SEL5 5'h0e
`define IPS_TAP_SEL6 5'h0f
`define IPS_TAP_SEL7 5'h10

`endif

// File: hdl/sub_clock_interval_prescaler.v
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "interval_prescaler_map.vh"

// Overview of operation
// (R1) Free-running 16-bit down-counter on divided clock
// (R2) Eight intervals, 2^n ticks, n 10..17
// (R3) Select one of eight taps among 17 stages
// (R4) Set flag on interval, except low-speed stop
// (R5) Interrupt request when flag and enable set
// (R6) Enabling with flag pending requests immediately
// (R7) Counter clear beats coincident tap overflow
// (R8) Handler writes zero to clear flag
// (R9) Set enable and clear flag together
// (R10) Tap output feeds watchdog count clock
// (R11) Counter clear also clears watchdog
// (R12) Clear reloads 0xffff; wraps after zero
// (R13) Control layout: flag7 enable6 select3:1 clear0
// (R14) Hardware clear on low-speed stop or main-mode oscillator off
// (R15) Reset clears counter and stops it
// (R16) Level interrupt, drops cycle after clear
module sub_clock_interval_prescaler #(
  parameter COUNT_WIDTH = 16,
  parameter ADDR_WIDTH = 3,
  parameter DATA_WIDTH = 8
) (
  // System
  input wire clock,
  input wire reset,
  // Register port
  input wire [ADDR_WIDTH-1:0] reg_addr,
  input wire [DATA_WIDTH-1:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output wire [DATA_WIDTH-1:0] reg_rdata,
  // Low-speed clock pins
  input wire crystal_low_speed_clock,
  input wire rc_low_speed_clock,
  // Clock controller status
  input wire crystal_osc_enable,
  input wire rc_osc_enable,
  input wire crystal_ready,
  input wire rc_ready,
  input wire low_speed_mode,
  input wire low_speed_source_rc,
  input wire stop_mode,
  // Watchdog side
  input wire watchdog_uses_prescaler,
  output wire watchdog_count_clock,
  output wire watchdog_clear,
  // Interrupt
  output wire interval_irq
);

  localparam CHAIN_WIDTH = COUNT_WIDTH + 1;

  // Tap stage index for a select code
  function [4:0] tap_of;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: tap_of = `IPS_TAP_SEL0;
        3'h1: tap_of = `IPS_TAP_SEL1;
        3'h2: tap_of = `IPS_TAP_SEL2;
        3'h3: tap_of = `IPS_TAP_SEL3;
        3'h4: tap_of = `IPS_TAP_SEL4;
        3'h5: tap_of = `IPS_TAP_SEL5;
        3'h6: tap_of = `IPS_TAP_SEL6;
        default: tap_of = `IPS_TAP_SEL7;
      endcase
    end
  endfunction

  // Strobe aimed at one register; both write decodes share it, the read port decodes with a case
  function reg_hit;
    input strobe;
    input [ADDR_WIDTH-1:0] addr;
    input [ADDR_WIDTH-1:0] target;
    begin
      reg_hit = strobe & (addr == target);
    end
  endfunction

  // A level that was high last cycle and is low now
  function went_low;
    input prev;
    input level;
    begin
      went_low = prev & ~level;
    end
  endfunction

  // One byte of the live count for the read port
  function [DATA_WIDTH-1:0] count_byte;
    input [COUNT_WIDTH-1:0] value;
    input high;
    begin
      if (high) begin
        count_byte = value[COUNT_WIDTH-1:COUNT_WIDTH-DATA_WIDTH];
      end else begin
        count_byte = value[DATA_WIDTH-1:0];
      end
    end
  endfunction

  // Synchronisers for both low-speed pins
  reg crystal_meta_ff;
  reg crystal_sync_ff;
  reg crystal_prev_ff;
  reg rc_meta_ff;
  reg rc_sync_ff;
  reg rc_prev_ff;
  reg [2:0] settle_ff;

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      crystal_meta_ff <= 1'b0;
      crystal_sync_ff <= 1'b0;
      crystal_prev_ff <= 1'b0;
      rc_meta_ff <= 1'b0;
      rc_sync_ff <= 1'b0;
      rc_prev_ff <= 1'b0;
      settle_ff <= 3'b000;
    end else begin
      crystal_meta_ff <= crystal_low_speed_clock;
      crystal_sync_ff <= crystal_meta_ff;
      crystal_prev_ff <= crystal_sync_ff;
      rc_meta_ff <= rc_low_speed_clock;
      rc_sync_ff <= rc_meta_ff;
      rc_prev_ff <= rc_sync_ff;
      settle_ff <= {settle_ff[1:0], 1'b1};
    end
  end

  // Edge history is trusted only once the chain has filled after reset;
  // otherwise a pin sitting high at release would look like a rising edge
  wire settled = settle_ff[2];
  wire crystal_rise = settled & crystal_sync_ff & ~crystal_prev_ff;
  wire rc_rise = settled & rc_sync_ff & ~rc_prev_ff;

  // Source choice: low-speed modes use their own oscillator only;
  // main modes prefer the crystal when both are stable.
  wire use_crystal = low_speed_mode ? ~low_speed_source_rc : crystal_ready;
  wire use_rc = low_speed_mode ? low_speed_source_rc : (~crystal_ready & rc_ready);

  // Registered one-hot source: the counter runs only from the cycle after a
  // source is usable, and edges of two sources are never mixed
  localparam [2:0] SRC_NONE = 3'b001;
  localparam [2:0] SRC_CRYSTAL = 3'b010;
  localparam [2:0] SRC_RC = 3'b100;

  reg [2:0] src_ff;
  reg [2:0] nxt_src;
  reg source_rise;

  always @* begin
    nxt_src = SRC_NONE;
    if (use_crystal) begin
      nxt_src = SRC_CRYSTAL;
    end else if (use_rc) begin
      nxt_src = SRC_RC;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      src_ff <= SRC_NONE; // (R15)
    end else begin
      src_ff <= nxt_src;
    end
  end

  always @* begin
    case (src_ff)
      SRC_CRYSTAL: source_rise = crystal_rise;
      SRC_RC: source_rise = rc_rise;
      SRC_NONE: source_rise = 1'b0;
      default: source_rise = 1'b0;
    endcase
  end

  // Hardware clear sources
  reg stop_prev_ff;
  reg crystal_en_prev_ff;
  reg rc_en_prev_ff;

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      stop_prev_ff <= 1'b0;
      crystal_en_prev_ff <= 1'b0;
      rc_en_prev_ff <= 1'b0;
    end else begin
      stop_prev_ff <= stop_mode;
      crystal_en_prev_ff <= crystal_osc_enable;
      rc_en_prev_ff <= rc_osc_enable;
    end
  end

  // Both cases need the oscillator to restart, so the running count is void
  wire stop_entry = stop_mode & ~stop_prev_ff & low_speed_mode; // (R14)
  wire crystal_stopped = went_low(crystal_en_prev_ff, crystal_osc_enable);
  wire rc_stopped = went_low(rc_en_prev_ff, rc_osc_enable);
  wire osc_disabled = ~low_speed_mode & (crystal_stopped | rc_stopped); // (R14)

  // Control register
  reg flag_ff;
  reg enable_ff;
  reg [2:0] select_ff;
  reg [DATA_WIDTH-1:0] rdata_ff;

  wire ctrl_write = reg_hit(reg_write, reg_addr, `IPS_ADDR_CONTROL);
  wire flag_clear_write = reg_hit(reg_write, reg_addr, `IPS_ADDR_FLAG_CLEAR);
  wire sw_clear = ctrl_write & reg_wdata[`IPS_BIT_CLEAR];
  wire hw_clear = stop_entry | osc_disabled;
  wire counter_clear = sw_clear | hw_clear;

  // Counter chain: 16 counter bits plus one wrap stage gives 17 stages
  reg div_ff;
  reg [COUNT_WIDTH-1:0] count_ff;
  reg wrap_ff;
  reg [CHAIN_WIDTH-1:0] nxt_chain;
  reg elapsed;
  reg [4:0] tap;

  // Seventeen stages: sixteen count bits with the wrap stage on top
  wire [CHAIN_WIDTH-1:0] chain = {wrap_ff, count_ff};
  // Every second edge of the chosen source is one count tick
  wire tick = source_rise & div_ff; // (R1)

  always @* begin
    tap = tap_of(select_ff); // (R2) (R3)
    nxt_chain = chain - {{(CHAIN_WIDTH-1){1'b0}}, 1'b1}; // (R12)
    // Down-counting borrow into the tap marks one full interval
    elapsed = tick & ~chain[tap] & nxt_chain[tap]; // (R3)
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      div_ff <= 1'b0;
      count_ff <= `IPS_COUNT_RELOAD; // (R15)
      wrap_ff <= `IPS_WRAP_RELOAD;
    end else begin
      // A clear restarts the divide-by-two too, so the first interval is whole
      if (counter_clear) begin
        div_ff <= 1'b0;
        count_ff <= `IPS_COUNT_RELOAD; // (R12)
        wrap_ff <= `IPS_WRAP_RELOAD;
      end else begin
        if (source_rise) begin
          div_ff <= ~div_ff; // (R1)
        end
        if (tick) begin
          count_ff <= nxt_chain[COUNT_WIDTH-1:0]; // (R1) (R12)
          wrap_ff <= nxt_chain[CHAIN_WIDTH-1];
        end
      end
    end
  end

  // Flag: interval event beats a simultaneous clear write, counter clear beats event
  wire low_speed_stop = stop_mode & low_speed_mode;
  wire flag_set = elapsed & ~counter_clear & ~low_speed_stop; // (R4) (R7)
  wire ctrl_flag_zero = ctrl_write & ~reg_wdata[`IPS_BIT_FLAG]; // (R8) (R9)
  wire status_flag_clear = flag_clear_write & reg_wdata[`IPS_BIT_STATUS_FLAG]; // (R8)
  wire flag_wr_clear = ctrl_flag_zero | status_flag_clear;

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      flag_ff <= 1'b0;
      enable_ff <= 1'b0;
      select_ff <= 3'h0;
    end else begin
      if (flag_set) begin
        flag_ff <= 1'b1; // (R4)
      end else if (flag_wr_clear) begin
        flag_ff <= 1'b0; // (R8)
      end
      if (ctrl_write) begin
        enable_ff <= reg_wdata[`IPS_BIT_ENABLE]; // (R13)
        select_ff <= reg_wdata[`IPS_SEL_HI:`IPS_SEL_LO]; // (R13)
      end
    end
  end

  // Read port: data in the cycle after the strobe only
  // Count bytes are live, so software reads high, low, high to catch a carry
  reg [DATA_WIDTH-1:0] nxt_rdata;

  always @* begin
    nxt_rdata = `IPS_ZERO_BYTE;
    if (reg_read) begin
      case (reg_addr)
        `IPS_ADDR_CONTROL: begin
          nxt_rdata[`IPS_BIT_FLAG] = flag_ff; // (R13)
          nxt_rdata[`IPS_BIT_ENABLE] = enable_ff;
          nxt_rdata[`IPS_SEL_HI:`IPS_SEL_LO] = select_ff;
        end
        `IPS_ADDR_STATUS: begin
          nxt_rdata[`IPS_BIT_STATUS_FLAG] = flag_ff;
        end
        `IPS_ADDR_COUNT_LO: begin
          nxt_rdata = count_byte(count_ff, 1'b0); // (R12)
        end
        `IPS_ADDR_COUNT_HI: begin
          nxt_rdata = count_byte(count_ff, 1'b1);
        end
        default: begin
          nxt_rdata = `IPS_ZERO_BYTE;
        end
      endcase
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      rdata_ff <= `IPS_ZERO_BYTE;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // Watchdog side: level of the selected tap and a clear pulse
  // Any counter clear restarts the tap, so with watchdog_uses_prescaler set the watchdog count restarts too
  reg wd_clock_ff;
  reg wd_clear_ff;

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      wd_clock_ff <= 1'b0;
      wd_clear_ff <= 1'b0;
    end else begin
      wd_clock_ff <= chain[tap]; // (R10)
      wd_clear_ff <= counter_clear & watchdog_uses_prescaler; // (R11)
    end
  end

  assign watchdog_count_clock = wd_clock_ff;
  assign watchdog_clear = wd_clear_ff;

  // Level from two flops, so a pending flag shows the cycle enable lands
  assign interval_irq = flag_ff & enable_ff; // (R5) (R6) (R16)

endmodule // sub_clock_interval_prescaler
`default_nettype wire

// File: verification/prescaler_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none
module prescaler_checker (
  // Watched ports
  input wire logic clock,
  input wire logic reset,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic watchdog_uses_prescaler,
  input wire logic watchdog_clear,
  input wire logic interval_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence ctl_read;
    reg_read && reg_addr == 3'h0;
  endsequence
  sequence flag_then_enable;
    ctl_read ##1 (reg_rdata[7] && reg_write && reg_addr == 3'h0 && reg_wdata[7] && reg_wdata[6]);
  endsequence
  AST_IRQ_OFF: assert property (reg_write && reg_addr == 3'h0 && !reg_wdata[6] |=> !interval_irq)
    else $error("irq stayed high");
  AST_IRQ_NOW: assert property (flag_then_enable |=> interval_irq)
    else $error("irq late");
  AST_CTL_ZERO: assert property (ctl_read |=> reg_rdata[5:4] == 2'b00 && !reg_rdata[0])
    else $error("control bits not zero");
  AST_UNMAPPED: assert property (reg_read && reg_addr > 3'h4 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_STATUS: assert property (reg_read && reg_addr == 3'h1 |=> reg_rdata[7:1] == 7'h00)
    else $error("status upper bits set");
  AST_IDLE: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data without read");
  AST_WD_CLR: assert property (reg_write && reg_addr == 3'h0 && reg_wdata[0] && watchdog_uses_prescaler |=> watchdog_clear)
    else $error("watchdog not cleared");
  AST_WD_CAUSE: assert property (watchdog_clear |-> $past(watchdog_uses_prescaler))
    else $error("watchdog cleared while unused");
endmodule // prescaler_checker
bind sub_clock_interval_prescaler prescaler_checker u_chk (.clock(clock), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .watchdog_uses_prescaler(watchdog_uses_prescaler),
  .watchdog_clear(watchdog_clear), .interval_irq(interval_irq));
`default_nettype wire

// File: verification/irq_watchdog_model.sv
`timescale 1ns/1ps
`default_nettype none
module irq_watchdog_model (
  // System
  input wire logic clock,
  input wire logic reset,
  // Prescaler outputs
  input wire logic count_clock,
  input wire logic clear,
  input wire logic irq,
  // Observed state
  output logic [15:0] wd_count_ff,
  output logic [7:0] irq_count_ff
);
  logic cc_ff;
  logic irq_ff;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cc_ff <= 1'b0;
      irq_ff <= 1'b0;
      wd_count_ff <= 16'h0000;
      irq_count_ff <= 8'h00;
    end else begin
      cc_ff <= count_clock;
      irq_ff <= irq;
      if (clear)
        wd_count_ff <= 16'h0000;
      else if (count_clock && !cc_ff)
        wd_count_ff <= wd_count_ff + 16'h0001;
      if (irq && !irq_ff)
        irq_count_ff <= irq_count_ff + 8'h01;
    end
  end
endmodule // irq_watchdog_model
`default_nettype wire

// File: verification/sub_clock_interval_prescaler_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; $display("wrong value at %0t got %h exp %h", $time, a, e); end end
module sub_clock_interval_prescaler_bench;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic xtal = 1'b0;
  logic xtal_ready = 1'b0;
  logic xtal_en = 1'b1;
  logic wd_sel = 1'b0;
  wire [7:0] reg_rdata;
  wire wd_cc;
  wire wd_clr;
  wire interval_irq;
  wire [15:0] wd_count;
  wire [7:0] irq_count;
  int bad_count = 0;
  int cmp_count = 0;
  int seed;
  int i;
  logic [7:0] w;
  always #10 clock = ~clock;
  // Low-speed clock deliberately off any multiple of the system period
  always #41 xtal = ~xtal;
  sub_clock_interval_prescaler u_dut (.clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .crystal_low_speed_clock(xtal), .rc_low_speed_clock(~xtal), .crystal_osc_enable(xtal_en),
    .rc_osc_enable(1'b1), .crystal_ready(xtal_ready), .rc_ready(1'b0), .low_speed_mode(1'b0),
    .low_speed_source_rc(1'b0), .stop_mode(1'b0), .watchdog_uses_prescaler(wd_sel),
    .watchdog_count_clock(wd_cc), .watchdog_clear(wd_clr), .interval_irq(interval_irq));
  irq_watchdog_model u_model (.clock(clock), .reset(reset), .count_clock(wd_cc),
    .clear(wd_clr), .irq(interval_irq), .wd_count_ff(wd_count), .irq_count_ff(irq_count));
  function automatic logic [7:0] ctl(input logic [7:0] d, input logic f);
    return {f, d[6], 2'b00, d[3:1], 1'b0};
  endfunction
  function automatic int interval_cycles(input int n);
    return (2 ** n) * 2 * 82 / 20;
  endfunction
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    seed = 32'hd1d47bc7;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    // Counter stays stopped while no source is usable
    for (i = 0; i < 6; i++) begin
      w = 8'($random(seed));
      wr(3'h0, w);
      rd(3'h0, ctl(w, 1'b0));
    end
    for (i = 5; i < 8; i++) rd(i[2:0], 8'h00);
    rd(3'h1, 8'h00);
    rd(3'h3, 8'hff);
    rd(3'h4, 8'hff);
    $display("test 1 done");
    xtal_ready <= 1'b1;
    wd_sel <= 1'b1;
    wr(3'h0, 8'h49);
    for (i = 0; i < 9000 && interval_irq !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    if (i == 9000) begin
      bad_count++;
      summarize();
    end
    `CHK(i - interval_cycles(10) > -40 && i - interval_cycles(10) < 40, 1'b1)
    // The model counts the rise one edge after the bench sees it
    @(posedge clock);
    #1;
    `CHK(irq_count, 8'h01)
    $display("test 2 done");
    wr(3'h0, 8'h88);
    #1;
    `CHK(interval_irq, 1'b0)
    rd(3'h0, 8'h88);
    @(posedge clock);
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    reg_wdata <= 8'hc8;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    #1;
    `CHK(interval_irq, 1'b1)
    wr(3'h0, 8'h48);
    #1;
    `CHK(interval_irq, 1'b0)
    rd(3'h0, 8'h48);
    `CHK(wd_count != 16'h0000, 1'b1)
    $display("test 3 done");
    wr(3'h0, 8'h49);
    @(posedge clock);
    #1;
    `CHK(wd_count, 16'h0000)
    $display("test 4 done");
    // About 366 ticks after the clear the high count byte has stepped down once
    repeat (3000) @(posedge clock);
    rd(3'h4, 8'hfe);
    @(posedge clock);
    xtal_en <= 1'b0;
    xtal_ready <= 1'b0;
    rd(3'h4, 8'hff);
    rd(3'h3, 8'hff);
    $display("test 5 done");
    summarize();
  end
endmodule // sub_clock_interval_prescaler_bench
`default_nettype wire
